// File: logic/exec_cfg.svh
// constant macros for the single-operand execution unit
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

// primary opcode bytes, modrm reg-field selectors and the no-operation length
`define OPC_GROUP_BYTE      8'hF6
`define OPC_GROUP_WIDE      8'hF7
`define OPC_NO_OPERATION    8'h90
`define REGSEL_INVERT       3'h2
`define REGSEL_NEGATE       3'h3
`define REGSEL_UMUL         3'h4
`define NOP_LENGTH          4'h1

// register port byte offsets
`define OFS_CTRL            4'h0
`define OFS_STATUS          4'h4
`define OFS_FLAGS           4'h8

// control register fields
`define CTRL_MODE_LSB       0
`define CTRL_MODE_MSB       1
`define CTRL_ALIGN_EN_BIT   2
`define CTRL_CPL_LSB        3
`define CTRL_CPL_MSB        4

// status register fields
`define STAT_KIND_LSB       0
`define STAT_KIND_MSB       2
`define STAT_UNKNOWN_BIT    3
`define STAT_COUNT_LSB      8
`define STAT_COUNT_MSB      15

// arithmetic flag positions inside the flag word
`define FLAG_CARRY          0
`define FLAG_PARITY         1
`define FLAG_AUX            2
`define FLAG_ZERO           3
`define FLAG_SIGN           4
`define FLAG_OVERFLOW       5
`define FLAG_WIDTH          6

// reset values and the user privilege level
`define FLAGS_RESET         6'h00
`define CPL_RESET           2'h0
`define ALIGN_EN_RESET      1'b0
`define USER_PRIVILEGE      2'h3

`endif

// File: logic/exec_fault_check.sv
// memory-operand fault selection by operating mode
`timescale 1ns/100ps
`include "exec_cfg.svh"
module exec_fault_check
	import exec_pkg::*;
(
	// operating context
	input  wire cpu_mode_t mode,
	input  wire logic [1:0] current_privilege_level,
	input  wire logic       align_en,
	// operand description
	input  wire logic       is_mem,
	input  wire logic       is_write,
	input  wire logic       no_fault,
	// detected conditions from segment and paging units
	input  wire logic       seg_not_writable,
	input  wire logic       over_limit,
	input  wire logic       via_stack_seg,
	input  wire logic       null_selector,
	input  wire logic       xlate_fail,
	input  wire logic       unaligned,
	// selected fault
	output exc_kind_t       kind,
	output logic            has_code
);

	// priority: protection, stack limit, translation, alignment
	always_comb begin
		kind     = exc_none;
		has_code = 1'b0;
		if (is_mem && !no_fault) begin
			unique case (mode)
				mode_protected: begin
					if (is_write && seg_not_writable) begin
						kind = exc_gp;
					end else if (null_selector && !via_stack_seg) begin
						kind = exc_gp;
					end else if (over_limit && !via_stack_seg) begin
						kind = exc_gp;
					end else if (over_limit) begin
						kind = exc_ss;
					end else if (xlate_fail) begin
						kind = exc_pf;
					end else if (align_en && unaligned && current_privilege_level == `USER_PRIVILEGE) begin
						kind = exc_ac;
					end
					has_code = (kind != exc_none);
				end
				mode_real: begin
					// paging and alignment do not apply, no error code pushed
					if (over_limit) begin
						kind = via_stack_seg ? exc_ss : exc_gp;
					end
				end
				mode_v86: begin
					if (over_limit) begin
						kind = via_stack_seg ? exc_ss : exc_gp;
					end else if (xlate_fail) begin
						kind = exc_pf;
					end else if (align_en && unaligned) begin
						kind = exc_ac;
					end
					has_code = (kind != exc_none);
				end
			endcase
		end
	end

endmodule // exec_fault_check

// File: logic/exec_pkg.sv
// types shared by the single-operand execution unit
package exec_pkg;
	typedef enum logic [1:0] {size_8, size_16, size_32} op_size_t;
	typedef enum logic [1:0] {mode_real, mode_protected, mode_v86} cpu_mode_t;
	typedef enum logic [2:0] {exc_none, exc_gp, exc_ss, exc_pf, exc_ac} exc_kind_t;
	typedef enum logic [2:0] {op_none, op_negate, op_invert, op_umul, op_nop} op_kind_t;
endpackage

// File: logic/exec_unit.sv
// negate / invert / no-operation execution datapath with fault checks
//
// Contract
// - negate is F6 or F7 with reg 3
// - negate writes two's complement to destination
// - negate carry clear only for zero operand
// - negate other arithmetic flags follow result
// - byte 90 only advances instruction pointer
// - no-operation is accumulator exchanged with itself
// - no-operation keeps flags, never faults
// - invert is F6 or F7 with reg 2
// - invert complements destination, flags kept
// - protected write to read-only segment faults
// - protected segment limit overrun faults, code zero
// - protected null data selector faults, code zero
// - stack limit overrun raises stack fault
// - failed translation raises page fault with code
// - protected unaligned at privilege 3 faults
// - real mode limit faults carry no code
// - virtual mode unaligned faults regardless privilege
// - unsigned multiply is F6 or F7 reg 4
// - multiply carry/overflow follow upper half zero
`timescale 1ns/100ps
`include "exec_cfg.svh"
module exec_unit
	import exec_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int PFC_W  = 32
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              resetn,
	// register port
	input  wire logic [3:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [31:0]       reg_rdata,
	// decoded instruction issue
	input  wire logic              issue,
	input  wire logic [7:0]        opcode,
	input  wire logic [2:0]        modrm_reg,
	input  wire op_size_t          op_size,
	input  wire logic              op_is_mem,
	input  wire logic [DATA_W-1:0] operand,
	input  wire logic              mul_upper_zero,
	// fault conditions for the memory operand
	input  wire logic              seg_not_writable,
	input  wire logic              over_limit,
	input  wire logic              via_stack_seg,
	input  wire logic              null_selector,
	input  wire logic              xlate_fail,
	input  wire logic [PFC_W-1:0]  xlate_code,
	input  wire logic              unaligned,
	// completion and write-back
	output logic                   done,
	output logic                   wb_valid,
	output logic                   wb_to_mem,
	output op_size_t               wb_size,
	output logic [DATA_W-1:0]      wb_data,
	output logic                   mul_start,
	output logic [3:0]             ip_advance,
	// arithmetic flags
	output logic [`FLAG_WIDTH-1:0] flags,
	// exception report
	output logic                   exc_valid,
	output exc_kind_t              exc_kind,
	output logic                   exc_has_code,
	output logic [PFC_W-1:0]       exc_code
);

	// width check: the size decode assumes a 32-bit datapath
	if (DATA_W != 32 || PFC_W < 1) begin : g_param_check
		$error("exec_unit: DATA_W must be 32 and PFC_W positive");
	end

	// architectural and control state
	logic [`FLAG_WIDTH-1:0] flags_ff;
	cpu_mode_t              mode_ff;
	logic                   align_en_ff;
	logic [1:0]             cpl_ff;
	exc_kind_t              last_kind_ff;
	logic                   unknown_ff;
	logic [7:0]             count_ff;
	logic [31:0]            rdata_ff;

	// output stage
	logic                   done_ff;
	logic                   wb_valid_ff;
	logic                   wb_mem_ff;
	op_size_t               wb_size_ff;
	logic [DATA_W-1:0]      wb_data_ff;
	logic                   mul_start_ff;
	logic [3:0]             ip_adv_ff;
	logic                   exc_valid_ff;
	exc_kind_t              exc_kind_ff;
	logic                   exc_code_en_ff;
	logic [PFC_W-1:0]       exc_code_ff;

	// decode
	op_kind_t               op;
	logic                   grp_byte;
	op_size_t               eff_size;
	exc_kind_t              fault_kind;
	logic                   fault_has_code;
	logic                   faulted;

	// datapath
	logic [DATA_W-1:0]      neg_res;
	logic [DATA_W-1:0]      inv_res;
	logic [DATA_W-1:0]      size_mask;
	logic [DATA_W-1:0]      sign_bit;
	logic [DATA_W-1:0]      nxt_result;
	logic [`FLAG_WIDTH-1:0] nxt_flags;

	// instruction decode from primary byte and reg field
	always_comb begin
		grp_byte = (opcode == `OPC_GROUP_BYTE);
		op       = op_none;
		if (opcode == `OPC_NO_OPERATION) begin
			op = op_nop;
		end else if (grp_byte || opcode == `OPC_GROUP_WIDE) begin
			if (modrm_reg == `REGSEL_NEGATE) begin
				op = op_negate;
			end else if (modrm_reg == `REGSEL_INVERT) begin
				op = op_invert;
			end else if (modrm_reg == `REGSEL_UMUL) begin
				op = op_umul;
			end
		end
		// F6 forces a byte operand; F7 takes the word or doubleword attribute
		eff_size = grp_byte ? size_8 : ((op_size == size_16) ? size_16 : size_32);
	end

	// operand width masks
	always_comb begin
		unique case (eff_size)
			size_8: begin
				size_mask = 32'h0000_00FF;
				sign_bit  = 32'h0000_0080;
			end
			size_16: begin
				size_mask = 32'h0000_FFFF;
				sign_bit  = 32'h0000_8000;
			end
			default: begin
				size_mask = 32'hFFFF_FFFF;
				sign_bit  = 32'h8000_0000;
			end
		endcase
	end

	// results, masked so upper bytes of narrow operands read zero
	assign neg_res = (32'h0000_0000 - operand) & size_mask;
	assign inv_res = (~operand) & size_mask;

	// memory-operand fault selection
	exec_fault_check u_fault (
		.mode             (mode_ff),
		.current_privilege_level              (cpl_ff),
		.align_en         (align_en_ff),
		.is_mem           (op_is_mem),
		.is_write         (op == op_negate || op == op_invert),
		.no_fault         (op == op_nop || op == op_none),
		.seg_not_writable (seg_not_writable),
		.over_limit       (over_limit),
		.via_stack_seg    (via_stack_seg),
		.null_selector    (null_selector),
		.xlate_fail       (xlate_fail),
		.unaligned        (unaligned),
		.kind             (fault_kind),
		.has_code         (fault_has_code)
	);
	assign faulted = (fault_kind != exc_none);

	// result and flag computation per operation
	always_comb begin
		nxt_result = 32'h0000_0000;
		nxt_flags  = flags_ff;
		unique case (op)
			op_negate: begin
				nxt_result                = neg_res;
				nxt_flags[`FLAG_CARRY]    = ((operand & size_mask) != 32'h0000_0000);
				nxt_flags[`FLAG_OVERFLOW] = ((operand & size_mask) == sign_bit);
				nxt_flags[`FLAG_SIGN]     = ((neg_res & sign_bit) != 32'h0000_0000);
				nxt_flags[`FLAG_ZERO]     = (neg_res == 32'h0000_0000);
				nxt_flags[`FLAG_AUX]      = (operand[3:0] != 4'h0);
				nxt_flags[`FLAG_PARITY]   = ~^neg_res[7:0];
			end
			op_invert: nxt_result = inv_res;
			op_umul: begin
				// sign, zero, aux and parity are undefined; they are left alone
				nxt_flags[`FLAG_CARRY]    = ~mul_upper_zero;
				nxt_flags[`FLAG_OVERFLOW] = ~mul_upper_zero;
			end
			// self-exchange of the accumulator moves nothing; unknown codes touch nothing
			op_nop, op_none: nxt_flags = flags_ff;
		endcase
	end

	// flag word: instructions update it unless faulted, software may overwrite
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			flags_ff <= `FLAGS_RESET;
		end else if (issue && !faulted) begin
			flags_ff <= nxt_flags;
		end else if (reg_wr && reg_addr == `OFS_FLAGS) begin
			flags_ff <= reg_wdata[`FLAG_WIDTH-1:0];
		end
	end

	// operating context written by software
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mode_ff     <= mode_real;
			align_en_ff <= `ALIGN_EN_RESET;
			cpl_ff      <= `CPL_RESET;
		end else if (reg_wr && reg_addr == `OFS_CTRL) begin
			// an unused mode code is refused and the old mode kept
			if (reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != 2'h3) begin
				mode_ff <= cpu_mode_t'(reg_wdata[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
			end
			align_en_ff <= reg_wdata[`CTRL_ALIGN_EN_BIT];
			cpl_ff      <= reg_wdata[`CTRL_CPL_MSB:`CTRL_CPL_LSB];
		end
	end

	// status: last fault, unknown opcode seen, fault count
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			last_kind_ff <= exc_none;
			unknown_ff   <= 1'b0;
			count_ff     <= 8'h00;
		end else begin
			if (issue && faulted) begin
				last_kind_ff <= fault_kind;
				count_ff     <= count_ff + 8'h01;
			end else if (reg_wr && reg_addr == `OFS_STATUS) begin
				last_kind_ff <= exc_none;
				count_ff     <= 8'h00;
			end
			// a new unknown opcode wins over a clear in the same cycle
			if (issue && op == op_none) begin
				unknown_ff <= 1'b1;
			end else if (reg_wr && reg_addr == `OFS_STATUS) begin
				unknown_ff <= 1'b0;
			end
		end
	end

	// register read data, one cycle after the strobe
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			rdata_ff <= 32'h0000_0000;
		end else if (reg_rd) begin
			rdata_ff <= 32'h0000_0000;
			unique case (reg_addr)
				`OFS_CTRL: begin
					rdata_ff[`CTRL_MODE_MSB:`CTRL_MODE_LSB] <= mode_ff;
					rdata_ff[`CTRL_ALIGN_EN_BIT]             <= align_en_ff;
					rdata_ff[`CTRL_CPL_MSB:`CTRL_CPL_LSB]    <= cpl_ff;
				end
				`OFS_STATUS: begin
					rdata_ff[`STAT_KIND_MSB:`STAT_KIND_LSB]   <= last_kind_ff;
					rdata_ff[`STAT_UNKNOWN_BIT]               <= unknown_ff;
					rdata_ff[`STAT_COUNT_MSB:`STAT_COUNT_LSB] <= count_ff;
				end
				`OFS_FLAGS: begin
					rdata_ff[`FLAG_WIDTH-1:0] <= flags_ff;
				end
				default: rdata_ff <= 32'h0000_0000; // unmapped reads zero
			endcase
		end else begin
			rdata_ff <= 32'h0000_0000;
		end
	end

	// completion and write-back stage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			done_ff      <= 1'b0;
			wb_valid_ff  <= 1'b0;
			wb_mem_ff    <= 1'b0;
			wb_size_ff   <= size_8;
			wb_data_ff   <= 32'h0000_0000;
			mul_start_ff <= 1'b0;
			ip_adv_ff    <= 4'h0;
		end else begin
			done_ff      <= issue;
			// a fault leaves the destination untouched
			wb_valid_ff  <= issue && !faulted && (op == op_negate || op == op_invert);
			mul_start_ff <= issue && !faulted && (op == op_umul);
			// the no-operation only steps past its own single byte
			ip_adv_ff    <= (issue && op == op_nop) ? `NOP_LENGTH : 4'h0;
			if (issue) begin
				wb_mem_ff  <= op_is_mem;
				wb_size_ff <= eff_size;
				wb_data_ff <= nxt_result;
			end
		end
	end

	// exception report stage
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			exc_valid_ff   <= 1'b0;
			exc_kind_ff    <= exc_none;
			exc_code_en_ff <= 1'b0;
			exc_code_ff    <= '0;
		end else begin
			exc_valid_ff <= issue && faulted;
			if (issue) begin
				exc_kind_ff    <= fault_kind;
				exc_code_en_ff <= fault_has_code;
				// page faults carry the translation code, the rest code zero
				exc_code_ff    <= (fault_kind == exc_pf) ? xlate_code : '0;
			end
		end
	end

	// outputs
	assign reg_rdata    = rdata_ff;
	assign flags        = flags_ff;
	assign done         = done_ff;
	assign wb_valid     = wb_valid_ff;
	assign wb_to_mem    = wb_mem_ff;
	assign wb_size      = wb_size_ff;
	assign wb_data      = wb_data_ff;
	assign mul_start    = mul_start_ff;
	assign ip_advance   = ip_adv_ff;
	assign exc_valid    = exc_valid_ff;
	assign exc_kind     = exc_kind_ff;
	assign exc_has_code = exc_code_en_ff;
	assign exc_code     = exc_code_ff;

endmodule // exec_unit

// File: verification/exec_unit_chk.sv
// concurrent checks on the ports of the single-operand execution unit
`timescale 1ns/100ps
`include "exec_cfg.svh"
module exec_unit_chk
	import exec_pkg::*;
#(
	parameter int DATA_W = 32,
	parameter int PFC_W  = 32
) (
	// clock and reset
	input wire logic                   clock,
	input wire logic                   resetn,
	// register port
	input wire logic [3:0]             reg_addr,
	input wire logic                   reg_wr,
	// instruction issue
	input wire logic                   issue,
	input wire logic [7:0]             opcode,
	input wire logic [2:0]             modrm_reg,
	input wire op_size_t               op_size,
	input wire logic                   op_is_mem,
	input wire logic [DATA_W-1:0]      operand,
	input wire logic                   mul_upper_zero,
	input wire logic [PFC_W-1:0]       xlate_code,
	// results
	input wire logic                   wb_valid,
	input wire logic [DATA_W-1:0]      wb_data,
	input wire logic                   mul_start,
	input wire logic [3:0]             ip_advance,
	input wire logic [`FLAG_WIDTH-1:0] flags,
	input wire logic                   exc_valid,
	input wire exc_kind_t              exc_kind,
	input wire logic [PFC_W-1:0]       exc_code
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	// full-width register operand, where result and flags are fully predictable
	wire wide_op = issue && opcode == `OPC_GROUP_WIDE && op_size == size_32 && !op_is_mem;
	// a software flag write may legally move the flags, so exclude it
	wire flag_wr = reg_wr && reg_addr == `OFS_FLAGS;

	a_negate_value: assert property (wide_op && modrm_reg == `REGSEL_NEGATE |=>
		wb_valid && wb_data == -$past(operand)) else $error("negate result wrong");
	a_negate_carry: assert property (wide_op && modrm_reg == `REGSEL_NEGATE |=>
		flags[`FLAG_CARRY] == ($past(operand) != '0)) else $error("negate carry wrong");
	a_negate_flags: assert property (wide_op && modrm_reg == `REGSEL_NEGATE |=>
		flags[`FLAG_ZERO] == (wb_data == '0) && flags[`FLAG_SIGN] == wb_data[DATA_W-1]
		&& flags[`FLAG_PARITY] == ~^wb_data[7:0]
		&& flags[`FLAG_OVERFLOW] == (wb_data == {1'b1, {(DATA_W-1){1'b0}}})) else $error("negate flags wrong");
	a_invert_keeps: assert property (wide_op && modrm_reg == `REGSEL_INVERT && !flag_wr |=>
		wb_valid && wb_data == ~$past(operand) && $stable(flags)) else $error("invert wrong");
	a_nop_quiet: assert property (issue && opcode == `OPC_NO_OPERATION && !flag_wr |=>
		ip_advance == `NOP_LENGTH && !wb_valid && !exc_valid && $stable(flags)) else $error("nop not quiet");
	a_mul_flags: assert property (wide_op && modrm_reg == `REGSEL_UMUL |=> mul_start
		&& flags[`FLAG_CARRY] == !$past(mul_upper_zero) && flags[`FLAG_OVERFLOW] == flags[`FLAG_CARRY])
		else $error("multiply flags wrong");
	a_fault_blocks: assert property (exc_valid |-> !wb_valid && !mul_start
		&& (flags == $past(flags) || $past(flag_wr))) else $error("fault did not suppress update");
	a_pf_code: assert property (issue ##1 (exc_valid && exc_kind == exc_pf) |->
		exc_code == $past(xlate_code)) else $error("page fault code wrong");
	a_code_zero: assert property (exc_valid && exc_kind != exc_pf |->
		exc_code == '0) else $error("error code not zero");
endmodule // exec_unit_chk

bind exec_unit exec_unit_chk #(.DATA_W(DATA_W), .PFC_W(PFC_W)) chk (.clock, .resetn, .reg_addr, .reg_wr,
	.issue, .opcode, .modrm_reg, .op_size, .op_is_mem, .operand, .mul_upper_zero, .xlate_code, .wb_valid,
	.wb_data, .mul_start, .ip_advance, .flags, .exc_valid, .exc_kind, .exc_code);

// File: verification/test_negate_invert_nop_exec_unit.sv
// self-checking bench for the single-operand execution unit
`timescale 1ns/100ps
`include "exec_cfg.svh"
module test_negate_invert_nop_exec_unit
	import exec_pkg::*;
;
	// stimulus, all valued at time zero
	logic        clock      = 1'b0;
	logic        resetn     = 1'b0;
	logic [3:0]  reg_addr   = 4'h0;
	logic [31:0] reg_wdata  = 32'h0;
	logic        reg_wr     = 1'b0;
	logic        reg_rd     = 1'b0;
	logic        issue      = 1'b0;
	logic [7:0]  opcode     = 8'h00;
	logic [2:0]  modrm_reg  = 3'h0;
	op_size_t    op_size    = size_8;
	logic        op_is_mem  = 1'b0;
	logic [31:0] operand    = 32'h0;
	logic [6:0]  cond       = 7'h00; // upper zero, nonwritable, limit, stack, null, xlate, unaligned
	logic [31:0] xlate_code = 32'hC0DE0005;
	// observed outputs and bookkeeping
	logic [31:0] reg_rdata, wb_data, exc_code, rd;
	logic        done, wb_valid, wb_to_mem, mul_start, exc_valid, exc_has_code;
	exc_kind_t   exc_kind;
	op_size_t    wb_size;
	logic [3:0]  ip_advance;
	logic [5:0]  flags, fl;
	int          bad_count = 0, comparisons = 0, cycles = 0, nfault = 0;

	exec_unit uut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .issue, .opcode,
		.modrm_reg, .op_size, .op_is_mem, .operand, .mul_upper_zero(cond[6]), .seg_not_writable(cond[5]),
		.over_limit(cond[4]), .via_stack_seg(cond[3]), .null_selector(cond[2]), .xlate_fail(cond[1]),
		.xlate_code, .unaligned(cond[0]), .done, .wb_valid, .wb_to_mem, .wb_size, .wb_data, .mul_start,
		.ip_advance, .flags, .exc_valid, .exc_kind, .exc_has_code, .exc_code);

	always #10 clock = ~clock;

	// hang guard: the whole run needs about a hundred cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 2000) begin
			bad_count++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic check(input logic [39:0] got, input logic [39:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	task automatic exec(input logic [7:0] opc, input logic [2:0] rg, input op_size_t sz, input logic mem,
			input logic [31:0] opnd, input logic [6:0] c);
		@(posedge clock);
		issue     <= 1'b1;
		opcode    <= opc;
		modrm_reg <= rg;
		op_size   <= sz;
		op_is_mem <= mem;
		operand   <= opnd;
		cond      <= c;
		@(posedge clock);
		issue <= 1'b0;
		cond  <= 7'h00;
		#1;
		check(done, 1'b1);
	endtask

	task automatic op_chk(input logic [7:0] opc, input logic [2:0] rg, input op_size_t sz,
			input logic [31:0] opnd, input logic [31:0] res, input logic [5:0] fe);
		exec(opc, rg, sz, 1'b0, opnd, 7'h00);
		check({wb_valid, exc_valid, wb_to_mem, ip_advance, wb_size}, {7'h40, (opc == `OPC_GROUP_BYTE) ? size_8 : sz});
		check(wb_data, res);
		check(flags, fe);
	endtask

	// byte negate of 5A gives A6 and flags 17 unless a fault suppresses it
	task automatic flt_chk(input logic [7:0] ctrl, input logic [6:0] c, input exc_kind_t k, input logic h);
		reg_write(`OFS_CTRL, {24'h0, ctrl});
		exec(`OPC_GROUP_BYTE, `REGSEL_NEGATE, size_8, 1'b1, 32'h0000005A, c);
		if (k != exc_none)
			nfault++;
		else
			fl = 6'h17;
		check({exc_valid, exc_kind, exc_has_code}, {k != exc_none, k, h});
		check(exc_code, k == exc_pf ? xlate_code : 32'h0);
		check({wb_valid, wb_to_mem, wb_size, wb_data}, {k == exc_none, 1'b1, size_8, 32'h000000A6});
		check(flags, fl);
	endtask

	// main sequence
	initial begin
		repeat (10) @(posedge clock);
		resetn <= 1'b1;
		for (int a = 0; a < 16; a += 4) begin
			reg_read(a[3:0], rd);
			check(rd, 32'h0);
		end
		reg_write(`OFS_CTRL, 32'h0000001F);
		reg_read(`OFS_CTRL, rd);
		check(rd, 32'h0000001C);
		reg_write(`OFS_CTRL, 32'h0);
		reg_write(`OFS_FLAGS, 32'hFFFFFFEA);
		reg_read(`OFS_FLAGS, rd);
		check({rd, flags}, {32'h0000002A, 6'h2A});
		$display("test registers finished");
		op_chk(`OPC_GROUP_WIDE, `REGSEL_NEGATE, size_32, 32'h00000001, 32'hFFFFFFFF, 6'h17);
		op_chk(`OPC_GROUP_BYTE, `REGSEL_NEGATE, size_32, 32'h00000000, 32'h00000000, 6'h0A);
		op_chk(`OPC_GROUP_BYTE, `REGSEL_NEGATE, size_8, 32'hFFFFFF80, 32'h00000080, 6'h31);
		op_chk(`OPC_GROUP_WIDE, `REGSEL_NEGATE, size_16, 32'h00008000, 32'h00008000, 6'h33);
		$display("test negate finished");
		op_chk(`OPC_GROUP_BYTE, `REGSEL_INVERT, size_32, 32'h000000A5, 32'h0000005A, 6'h33);
		op_chk(`OPC_GROUP_WIDE, `REGSEL_INVERT, size_16, 32'h00001234, 32'h0000EDCB, 6'h33);
		op_chk(`OPC_GROUP_WIDE, `REGSEL_INVERT, size_32, 32'h00000000, 32'hFFFFFFFF, 6'h33);
		$display("test invert finished");
		exec(`OPC_GROUP_WIDE, `REGSEL_UMUL, size_32, 1'b0, 32'h00000002, 7'h40);
		check({mul_start, wb_valid}, 2'b10);
		check(flags, 6'h12);
		exec(`OPC_GROUP_WIDE, `REGSEL_UMUL, size_16, 1'b0, 32'h00000002, 7'h00);
		check(flags, 6'h33);
		reg_write(`OFS_CTRL, 32'h0000001D);
		exec(`OPC_NO_OPERATION, 3'h0, size_32, 1'b1, 32'h00001234, 7'h3F);
		check(ip_advance, `NOP_LENGTH);
		check(wb_valid, 1'b0);
		check({exc_valid, flags}, {1'b0, 6'h33});
		exec(8'h00, 3'h0, size_32, 1'b0, 32'h00000005, 7'h00);
		check({wb_valid, exc_valid, flags}, {2'b00, 6'h33});
		$display("test multiply and nop finished");
		fl = 6'h33;
		flt_chk(8'h01, 7'h20, exc_gp, 1'b1);
		flt_chk(8'h01, 7'h10, exc_gp, 1'b1);
		flt_chk(8'h01, 7'h04, exc_gp, 1'b1);
		flt_chk(8'h01, 7'h18, exc_ss, 1'b1);
		flt_chk(8'h01, 7'h02, exc_pf, 1'b1);
		flt_chk(8'h05, 7'h01, exc_none, 1'b0);
		flt_chk(8'h1D, 7'h01, exc_ac, 1'b1);
		flt_chk(8'h00, 7'h10, exc_gp, 1'b0);
		flt_chk(8'h00, 7'h18, exc_ss, 1'b0);
		flt_chk(8'h04, 7'h03, exc_none, 1'b0);
		flt_chk(8'h06, 7'h01, exc_ac, 1'b1);
		reg_read(`OFS_STATUS, rd);
		check({rd[15:8], rd[3], rd[2:0]}, {nfault[7:0], 1'b1, exc_ac});
		reg_write(`OFS_STATUS, 32'h0);
		reg_read(`OFS_STATUS, rd);
		check(rd, 32'h0);
		$display("test faults finished");
		tally_and_finish();
	end
endmodule // test_negate_invert_nop_exec_unit
